// file: tb/psmc_core_model.sv
// cpu and interrupt source model facing the power save block
module psmc_core_model (
  input  wire logic       hclk,           // system clock
  input  wire logic       hresetn,        // async reset, low
  input  wire logic       go,             // start a request
  input  wire logic [1:0] op,             // 0 sleep, 1 idle, 2 interrupt only
  input  wire logic [4:0] dly,            // cycles to interrupt, 31 none
  input  wire logic       cpu_clk_en_ff,  // cpu clock enable
  output logic            ps_instr_exec,    // instruction pulse
  output logic            ps_instr_operand, // sleep or idle
  output logic            irq_pending     // enabled interrupt
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [4:0] cnt_ff;
  logic       arm_ff;
  logic       low_ff;
  // after a sleep or idle request the interrupt stays up until the cpu has stopped and run again, so a slow handler is modelled
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ps_instr_exec <= 1'b0;
      ps_instr_operand <= 1'b0;
      irq_pending <= 1'b0;
      cnt_ff <= 5'h00;
      arm_ff <= 1'b0;
      low_ff <= 1'b0;
    end else begin
      ps_instr_exec <= go && (op != 2'h2);
      ps_instr_operand <= op[0];
      if (!cpu_clk_en_ff) low_ff <= 1'b1;
      if (irq_pending && low_ff && cpu_clk_en_ff) begin
        irq_pending <= 1'b0;
        low_ff <= 1'b0;
      end
      if (go) begin
        arm_ff <= (dly != 5'h1F);
        cnt_ff <= dly;
        low_ff <= (op == 2'h2);
      end else if (arm_ff && cnt_ff != 5'h00) begin
        cnt_ff <= cnt_ff - 5'h01;
      end else if (arm_ff) begin
        arm_ff <= 1'b0;
        irq_pending <= 1'b1;
      end
    end
  end
endmodule : psmc_core_model

// file: tb/psmc_properties.sv
// assertion checker on the power save mode control top ports
module psmc_properties (
  input wire logic       hclk,             // system clock
  input wire logic       hresetn,          // async reset, low
  input wire logic       ps_instr_exec,     // instruction pulse
  input wire logic       ps_instr_operand,  // 0 sleep, 1 idle
  input wire logic       irq_pending,       // enabled interrupt
  input wire logic       watchdog_timeout,  // watchdog timeout
  input wire logic       cpu_clk_en_ff,    // cpu clock enable
  input wire logic       sys_clk_en_ff,    // system clock on
  input wire logic       periph_clk_en_ff, // peripherals on
  input wire logic       monitor_active_ff, // clock monitor on
  input wire logic       watchdog_clear_ff, // watchdog clear
  input wire logic       ret_reg_en_ff,    // retention regulator
  input wire logic       bandgap_en_ff,    // band gaps on
  input wire logic [1:0] sleep_var_ff      // sleep variant
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // entry takes two edges, so the sleep or idle outputs are seen one cycle after the enter state
  property p_sleep; ps_instr_exec && !ps_instr_operand |=> ##1 !sys_clk_en_ff && !cpu_clk_en_ff && !periph_clk_en_ff;
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep left a clock on");
  property p_idle; ps_instr_exec && ps_instr_operand |=> ##1 !cpu_clk_en_ff && sys_clk_en_ff && periph_clk_en_ff; endproperty
  a_idle: assert property (p_idle) else $error("idle clocks wrong");
  property p_monitor; !sys_clk_en_ff |-> !monitor_active_ff; endproperty
  a_monitor: assert property (p_monitor) else $error("clock monitor on in sleep");
  property p_wake; !sys_clk_en_ff && (irq_pending || watchdog_timeout) |=> sys_clk_en_ff && periph_clk_en_ff; endproperty
  a_wake: assert property (p_wake) else $error("no wake from sleep");
  property p_held; ps_instr_exec ##1 irq_pending |=> ##1 sys_clk_en_ff && periph_clk_en_ff; endproperty
  a_held: assert property (p_held) else $error("held interrupt did not wake");
  property p_ret; ret_reg_en_ff |-> !sys_clk_en_ff && sleep_var_ff[1]; endproperty
  a_ret: assert property (p_ret) else $error("retention regulator outside sleep");
  property p_var; sys_clk_en_ff |-> sleep_var_ff == 2'h0 && bandgap_en_ff; endproperty
  a_var: assert property (p_var) else $error("sleep variant outside sleep");
  property p_gap; !bandgap_en_ff |-> !sleep_var_ff[0]; endproperty
  a_gap: assert property (p_gap) else $error("band gaps off in fast wake");
  property p_clr; watchdog_clear_ff |-> $past(ps_instr_exec) ##1 !watchdog_clear_ff; endproperty
  a_clr: assert property (p_clr) else $error("watchdog clear not one entry pulse");
endmodule : psmc_properties

// file: tb/psmc_top_bench.sv
// self-checking bench for the power save mode control block
`include "psmc_params.svh"
module psmc_top_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic hclk = 0, hresetn = 0, hwrite = 0, wd_tmo = 0, go = 0;
  logic [11:0] haddr = 12'h000;
  logic [1:0] htrans = 2'h0, op = 2'h0;
  logic [31:0] hwdata = 32'h0, hrdata, q;
  logic [4:0] dly = 5'h1F;
  logic [2:0] osc_sel_ff;
  logic [1:0] sleep_var_ff;
  logic hready, hresp, exec, oper, irq, cpu, sys, per, rc_on, mon, clr, ret, gap, oreq;
  int fails = 0, compares = 0, cyc = 0, clr_n = 0, oreq_n = 0;
  psmc_top dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hready), .hresp(hresp),
    .ps_instr_exec(exec), .ps_instr_operand(oper), .irq_pending(irq), .watchdog_timeout(wd_tmo),
    .cpu_clk_en_ff(cpu), .sys_clk_en_ff(sys), .periph_clk_en_ff(per), .lp_rc_en_ff(rc_on), .monitor_active_ff(mon),
    .watchdog_clear_ff(clr), .ret_reg_en_ff(ret), .bandgap_en_ff(gap), .osc_sel_ff(osc_sel_ff), .osc_req_ff(oreq),
    .sleep_var_ff(sleep_var_ff));
  psmc_core_model core_u (.hclk(hclk), .hresetn(hresetn), .go(go), .op(op), .dly(dly), .cpu_clk_en_ff(cpu),
    .ps_instr_exec(exec), .ps_instr_operand(oper), .irq_pending(irq));
  always #25 hclk = ~hclk;
  // watchdog clear pulses and a hang limit well above the run length
  always @(posedge hclk) begin
    clr_n += (clr === 1'b1);
    oreq_n += (oreq === 1'b1);
    cyc++;
    if (cyc == 20000) begin
      fails++;
      finish_test();
    end
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      fails++;
    end
  endtask : chk
  // one single word transfer, held until the slave is ready in each phase
  task ahb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    q = hrdata;
  endtask : ahb
  task pm(input logic [1:0] o, input logic [4:0] d);
    go <= 1'b1;
    op <= o;
    dly <= d;
    @(posedge hclk);
    go <= 1'b0;
  endtask : pm
  task t_regs;
    ahb(0, `PSMC_OFF_CLK_DIV_CTL, 0); chk(q, 32'h0);
    chk({31'h0, hresp}, 32'h0);
    ahb(0, `PSMC_OFF_CFG, 0); chk(q, 32'h1);
    ahb(0, 12'h0FC, 0); chk(q, 32'h0);
    ahb(1, `PSMC_OFF_OSCCTL, 32'h3);
    ahb(0, `PSMC_OFF_OSCCTL, 0); chk(q, 32'h0);
    ahb(1, `PSMC_OFF_CFG, 32'h0);
    ahb(1, `PSMC_OFF_OSCCTL, 32'h5);
    ahb(0, `PSMC_OFF_OSCCTL, 0); chk(q, 32'h5);
    chk(32'(oreq_n), 32'h1);
  endtask : t_regs
  // all four variants, then retention asked for with the config bit left unprogrammed
  task t_sleep;
    logic [3:0] cf;
    logic [1:0] v;
    int n0;
    for (int i = 0; i < 5; i++) begin
      cf = (i == 4) ? 4'hE : 4'hC;
      v = (i == 4) ? 2'h2 : i[1:0];
      ahb(1, `PSMC_OFF_CFG, {28'h0, cf});
      ahb(1, `PSMC_OFF_RESET_CTL, {19'h0, v[1], 3'h0, v[0], 8'h00});
      n0 = clr_n;
      pm(2'h0, 5'd6);
      repeat (40) if (sys !== 1'b0) @(posedge hclk);
      chk({24'h0, sleep_var_ff, ret, gap, rc_on, per, cpu, mon}, {24'h0, v, v[1] & ~cf[1], v[0], 4'h8});
      repeat (40) if (sys !== 1'b1) @(posedge hclk);
      @(posedge hclk);
      chk({28'h0, mon, osc_sel_ff}, 32'hD);
      chk(32'(clr_n - n0), 32'h1);
    end
  endtask : t_sleep
  task t_idle;
    int n0;
    for (int i = 0; i < 2; i++) begin
      ahb(1, `PSMC_OFF_CFG, i ? 32'h4 : 32'h8);
      n0 = clr_n;
      pm(2'h1, 5'h1F);
      repeat (40) if (cpu !== 1'b0) @(posedge hclk);
      chk({28'h0, sys, per, rc_on, cpu}, 32'hE);
      wd_tmo <= 1'b1;
      @(posedge hclk);
      wd_tmo <= 1'b0;
      @(posedge hclk);
      chk({31'h0, cpu}, 32'h1);
      chk(32'(clr_n - n0), 32'(i));
    end
  endtask : t_idle
  // count cpu enables per window; the peripheral side must never slow
  task t_doze;
    int n;
    logic ok;
    for (int k = 0; k < 10; k++) begin
      ahb(1, `PSMC_OFF_CLK_DIV_CTL, {16'h0, k == 9, (k > 7) ? 3'h3 : k[2:0], 1'b1, 11'h0});
      if (k > 7) pm(2'h2, 5'd3);
      repeat (12) @(posedge hclk);
      n = 0;
      ok = 1'b1;
      repeat (256) begin
        @(posedge hclk);
        n += (cpu === 1'b1);
        ok &= (sys === 1'b1) && (per === 1'b1);
      end
      chk({31'h0, ok}, 32'h1);
      if (k < 8) chk(32'(n >= (256 >> k) - 1 && n <= (256 >> k) + 1), 32'h1);
      else chk(32'(n), (k == 9) ? 32'd256 : 32'd32);
    end
    ahb(1, `PSMC_OFF_CLK_DIV_CTL, 32'h0);
  endtask : t_doze
  task finish_test;
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : finish_test
  initial begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_regs();
    t_sleep();
    t_idle();
    t_doze();
    finish_test();
  end
endmodule : psmc_top_bench
bind psmc_top psmc_properties chk_u (.hclk(hclk), .hresetn(hresetn), .ps_instr_exec(ps_instr_exec),
  .ps_instr_operand(ps_instr_operand), .irq_pending(irq_pending), .watchdog_timeout(watchdog_timeout),
  .cpu_clk_en_ff(cpu_clk_en_ff), .sys_clk_en_ff(sys_clk_en_ff), .periph_clk_en_ff(periph_clk_en_ff),
  .monitor_active_ff(monitor_active_ff), .watchdog_clear_ff(watchdog_clear_ff), .ret_reg_en_ff(ret_reg_en_ff),
  .bandgap_en_ff(bandgap_en_ff), .sleep_var_ff(sleep_var_ff));

// file: verilog/psmc_ahb_regs.sv
// ahb-lite slave front end: address phase capture
module psmc_ahb_regs (
  input  wire logic        hclk,      // system clock
  input  wire logic        hresetn,   // async reset, low
  input  wire logic        hsel,      // slave select
  input  wire logic [1:0]  htrans,    // transfer type
  input  wire logic        hwrite,    // write when high
  input  wire logic [11:0] haddr,     // byte address
  input  wire logic        hready,    // bus ready
  output logic             wr_ff,     // write data phase
  output logic             rd_ff,     // read data phase
  output logic [11:0]      addr_ff    // latched address
);
  // capture the address phase; every transfer ends in one data cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ff   <= 1'b0;
      rd_ff   <= 1'b0;
      addr_ff <= 12'h000;
    end else if (hready) begin
      wr_ff   <= hsel && htrans[1] && hwrite;
      rd_ff   <= hsel && htrans[1] && !hwrite;
      addr_ff <= haddr;
    end
  end
endmodule : psmc_ahb_regs

// file: verilog/psmc_doze_div.sv
// cpu clock enable divider for the slowed cpu mode
module psmc_doze_div (
  input  wire logic              hclk,      // system clock
  input  wire logic              hresetn,   // async reset, low
  input  wire logic              active,    // slowdown in effect
  input  wire psmc_pkg::psmc_ratio_t ratio, // ratio code
  output logic                   cpu_en     // cpu enable pulse
);
  import psmc_pkg::*;
  logic [7:0] cnt_ff;
  logic [7:0] lim;

  // limit is the divisor minus one; the divisor doubles with each code step
  assign lim = 8'(({1'b0, 8'hFF} >> (4'h8 - {1'b0, ratio})));

  // a free counter keeps the cpu domain aligned with peripheral edges
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_ff <= 8'h00;
    end else if (!active || cnt_ff >= lim) begin
      cnt_ff <= 8'h00;
    end else begin
      cnt_ff <= cnt_ff + 8'h01;
    end
  end

  assign cpu_en = !active || (cnt_ff == lim);
endmodule : psmc_doze_div

// file: verilog/psmc_params.svh
// constants for the power save mode control block
`ifndef PSMC_PARAMS_SVH
`define PSMC_PARAMS_SVH
`define PSMC_OFF_CLK_DIV_CTL    12'h000
`define PSMC_OFF_RESET_CTL      12'h004
`define PSMC_OFF_OSCCTL         12'h008
`define PSMC_OFF_STATUS         12'h00C
`define PSMC_OFF_CFG            12'h010
`define PSMC_CLK_DIV_CTL_RST    16'h0000
`define PSMC_RESET_CTL_RST      16'h0000
`define PSMC_CFG_RST            16'h0001
`define PSMC_SLOWDOWN_EN_BIT    11
`define PSMC_DOZE_LSB           12
`define PSMC_RET_ON_IRQ_BIT     15
`define PSMC_RETENTION_EN_BIT   12
`define PSMC_FAST_WAKE_BIT      8
`define PSMC_CFG_LOCK_BIT       0
`define PSMC_CFG_RET_CFG_N_BIT  1
`define PSMC_CFG_WATCHDOG_BIT   2
`define PSMC_CFG_MONITOR_BIT    3
`define PSMC_MODE_SLEEP     1'h0
`define PSMC_MODE_IDLE      1'h1
`endif

// file: verilog/psmc_pkg.sv
// types shared by the power save mode control files
package psmc_pkg;
  typedef enum logic [1:0] {
    PSMC_RUN,
    PSMC_ENTER,
    PSMC_SLEEP,
    PSMC_IDLE
  } psmc_state_e;
  typedef logic [2:0] psmc_ratio_t;
  typedef logic [1:0] psmc_sleep_var_t;
endpackage : psmc_pkg

// file: verilog/psmc_top.sv
// power save mode control: sleep, idle, retention and cpu slowdown
`include "psmc_params.svh"
// Behaviour
// - sleep instruction stops cpu, system and peripheral clocks and halts execution until wake
// - idle instruction halts cpu, peripherals keep running
// - enabled interrupt, watchdog timeout or reset ends sleep or idle
// - sleep shuts down the system clock source and on-chip oscillator
// - fail safe clock monitor is off throughout sleep
// - low power rc clock runs in sleep when watchdog enabled
// - watchdog count cleared just before sleep entry
// - system-clocked peripherals off in sleep; change detect and external-clocked stay
// - wake from sleep resumes on the clock source selected at entry
// - watchdog count cleared on idle entry
// - system clock stays on in idle; peripherals keep running
// - rc clock runs in idle if watchdog or clock monitor enabled
// - idle wake reapplies cpu clock immediately
// - interrupt during the instruction is held until entry completes, then wakes
// - retention regulator only in sleep, config bit zero and enable one
// - retention and fast wake bits decode four sleep variants
// - fast wake keeps regulator band gaps on in sleep
// - slowdown divides only the cpu clock, peripherals unchanged
// - three bit ratio field picks one of eight ratios, reset 1:1
// - return on interrupt bit makes interrupts restore full cpu speed
// - slow cpu and peripheral domains kept in step
// - new oscillator request honoured only while clock config unlocked
module psmc_top (
  input  wire logic        hclk,              // system clock
  input  wire logic        hresetn,           // async reset, low
  input  wire logic        hsel,              // ahb select
  input  wire logic [11:0] haddr,             // ahb address
  input  wire logic [1:0]  htrans,            // ahb transfer type
  input  wire logic        hwrite,            // ahb write
  input  wire logic [2:0]  hsize,             // ahb size, word only
  input  wire logic [31:0] hwdata,            // ahb write data
  input  wire logic        hready,            // ahb bus ready
  output logic [31:0]      hrdata,            // ahb read data
  output logic             hreadyout,         // ahb ready out
  output logic             hresp,             // ahb response
  input  wire logic        ps_instr_exec,     // power save instruction pulse
  input  wire logic        ps_instr_operand,  // 0 sleep, 1 idle
  input  wire logic        irq_pending,       // enabled interrupt pending
  input  wire logic        watchdog_timeout,  // watchdog timeout pulse
  output logic             cpu_clk_en_ff,     // cpu clock enable
  output logic             sys_clk_en_ff,     // system clock source on
  output logic             periph_clk_en_ff,  // system-clocked peripherals on
  output logic             lp_rc_en_ff,       // low power rc clock on
  output logic             monitor_active_ff, // clock monitor running
  output logic             watchdog_clear_ff, // watchdog clear pulse
  output logic             ret_reg_en_ff,     // retention regulator on
  output logic             bandgap_en_ff,     // regulator band gaps on
  output logic [2:0]       osc_sel_ff,        // active oscillator select
  output logic             osc_req_ff,        // oscillator switch request pulse
  output logic [1:0]       sleep_var_ff       // sleep variant in use
);
  import psmc_pkg::*;

  // sequencer state
  psmc_state_e state_ff;
  psmc_state_e nxt_state;

  // bus front end
  logic        wr_ff;
  logic        rd_ff;
  logic [11:0] addr_ff;

  // software registers
  logic [15:0] clk_div_ctl_ff;
  logic [15:0] reset_ctl_ff;
  logic [15:0] cfg_ff;
  logic [2:0]  osc_new_ff;

  // derived controls
  logic        mode_ff;
  logic        irq_held_ff;
  logic        doze_act_ff;
  logic        cpu_en;
  logic        wake;
  logic        fast_wake;
  logic        retention_en;
  logic        watchdog_en;
  logic        monitor_en;
  logic [31:0] nxt_rdata;

  // register map, one aligned word each, upper half reads zero
  //   0x000 clock divider control: [15] return on interrupt,
  //         [14:12] cpu ratio code, [11] cpu slowdown enable
  //   0x004 reset control: [12] retention enable, [8] fast wake
  //   0x008 oscillator control: [2:0] new oscillator select
  //   0x00C status, read only: [6] slowdown active, [5:4] sleep
  //         variant, [3] retention regulator, [2] mode, [1:0] state
  //   0x010 configuration: [0] lock, [1] retention config (low
  //         means programmed), [2] watchdog enable, [3] monitor enable
  // unmapped offsets read zero and ignore writes, so software
  // probing an empty slot never disturbs the power state

  assign fast_wake    = reset_ctl_ff[`PSMC_FAST_WAKE_BIT];
  assign retention_en = reset_ctl_ff[`PSMC_RETENTION_EN_BIT];
  assign watchdog_en  = cfg_ff[`PSMC_CFG_WATCHDOG_BIT];
  assign monitor_en   = cfg_ff[`PSMC_CFG_MONITOR_BIT];

  // decodes retention and fast wake as a sleep variant
  function automatic psmc_sleep_var_t sleep_var(input logic r, input logic v);
    sleep_var = {r, v};
  endfunction : sleep_var

  // write strobe for one register offset, shared by the oscillator request and the slowdown enable
  function automatic logic reg_hit(input logic wr, input logic [11:0] a, input logic [11:0] off);
    reg_hit = wr && (a == off);
  endfunction : reg_hit

  // bus timing: zero wait states; a write lands at the edge that
  // closes its data phase, a read is latched at the address edge
  // so hrdata stands through the whole data phase
  psmc_ahb_regs u_bus (
    .hclk    (hclk),
    .hresetn (hresetn),
    .hsel    (hsel),
    .htrans  (htrans),
    .hwrite  (hwrite),
    .haddr   (haddr),
    .hready  (hready),
    .wr_ff   (wr_ff),
    .rd_ff   (rd_ff),
    .addr_ff (addr_ff)
  );

  // zero wait states, always okay
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // software registers; configuration resets locked so a stray
  // oscillator write before boot code runs is refused
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      clk_div_ctl_ff <= `PSMC_CLK_DIV_CTL_RST;
      reset_ctl_ff   <= `PSMC_RESET_CTL_RST;
      cfg_ff         <= `PSMC_CFG_RST;
    end else if (wr_ff) begin
      unique case (addr_ff)
        `PSMC_OFF_CLK_DIV_CTL: clk_div_ctl_ff <= hwdata[15:0];
        `PSMC_OFF_RESET_CTL:   reset_ctl_ff   <= hwdata[15:0];
        `PSMC_OFF_CFG:         cfg_ff         <= hwdata[15:0];
        default: ;
      endcase
    end
  end

  // oscillator request; a locked configuration ignores the write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      osc_new_ff <= 3'h0;
      osc_sel_ff <= 3'h0;
      osc_req_ff <= 1'b0;
    end else begin
      osc_req_ff <= 1'b0;
      if (reg_hit(wr_ff, addr_ff, `PSMC_OFF_OSCCTL) && !cfg_ff[`PSMC_CFG_LOCK_BIT]) begin
        osc_new_ff <= hwdata[2:0];
        osc_sel_ff <= hwdata[2:0];
        osc_req_ff <= 1'b1;
      end
    end
  end

  // read mux, latched so hrdata comes from a flop
  // the mux looks at the live address, since the data phase follows
  always_comb begin
    nxt_rdata = 32'h00000000;
    unique case (haddr)
      `PSMC_OFF_CLK_DIV_CTL: nxt_rdata = {16'h0000, clk_div_ctl_ff};
      `PSMC_OFF_RESET_CTL:   nxt_rdata = {16'h0000, reset_ctl_ff};
      `PSMC_OFF_OSCCTL: nxt_rdata = {29'h00000000, osc_new_ff};
      `PSMC_OFF_STATUS: nxt_rdata = {25'h0000000, doze_act_ff, sleep_var_ff,
                                     ret_reg_en_ff, mode_ff, state_ff};
      `PSMC_OFF_CFG:    nxt_rdata = {16'h0000, cfg_ff};
      default:          nxt_rdata = 32'h00000000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (hready && hsel && htrans[1] && !hwrite) begin
      hrdata <= nxt_rdata;
    end
  end

  // interrupt during the instruction is held, then wakes once entry completes
  // without the hold a short pulse in the entry cycle would be lost
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_held_ff <= 1'b0;
    end else if (state_ff == PSMC_ENTER) begin
      irq_held_ff <= irq_pending || watchdog_timeout;
    end else if (state_ff == PSMC_RUN) begin
      irq_held_ff <= 1'b0;
    end
  end

  // any of the three live or held sources ends sleep or idle
  assign wake = irq_pending || watchdog_timeout || irq_held_ff;

  // power save sequencer; reset itself is the third wake source
  // timeline: instruction seen in run, one enter cycle in which the
  // watchdog is cleared and late interrupts are held, then sleep or
  // idle; a wake in either returns to run at the very next edge
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      PSMC_RUN: begin
        // only a running cpu can issue the instruction
        if (ps_instr_exec) begin
          nxt_state = PSMC_ENTER;
        end
      end
      PSMC_ENTER: begin
        // entry always completes, even with a wake already pending
        nxt_state = (mode_ff == `PSMC_MODE_IDLE) ? PSMC_IDLE : PSMC_SLEEP;
      end
      PSMC_SLEEP: begin
        if (wake) begin
          nxt_state = PSMC_RUN;
        end
      end
      PSMC_IDLE: begin
        if (wake) begin
          nxt_state = PSMC_RUN;
        end
      end
    endcase
  end

  // the operand is captured with the instruction so a later change cannot switch mode
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_ff <= PSMC_RUN;
      mode_ff  <= `PSMC_MODE_SLEEP;
    end else begin
      state_ff <= nxt_state;
      if (state_ff == PSMC_RUN && ps_instr_exec) begin
        mode_ff <= ps_instr_operand;
      end
    end
  end

  // watchdog cleared in the entry cycle, before sleep or idle takes hold
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      watchdog_clear_ff <= 1'b0;
    end else begin
      watchdog_clear_ff <= (state_ff == PSMC_RUN) && ps_instr_exec && watchdog_en;
    end
  end

  // slowdown; return on interrupt drops it, otherwise interrupts leave it alone
  // limitation: after such a return software must rewrite the enable to slow again
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      doze_act_ff <= 1'b0;
    end else if (irq_pending && clk_div_ctl_ff[`PSMC_RET_ON_IRQ_BIT]) begin
      doze_act_ff <= 1'b0;
    end else if (reg_hit(wr_ff, addr_ff, `PSMC_OFF_CLK_DIV_CTL)) begin
      doze_act_ff <= hwdata[`PSMC_SLOWDOWN_EN_BIT];
    end else if (!clk_div_ctl_ff[`PSMC_SLOWDOWN_EN_BIT]) begin
      doze_act_ff <= 1'b0;
    end
  end

  // the cpu rate is an enable from a divider, never a second clock,
  // so both domains share every edge and need no crossing logic
  psmc_doze_div u_div (
    .hclk    (hclk),
    .hresetn (hresetn),
    .active  (doze_act_ff),
    .ratio   (clk_div_ctl_ff[`PSMC_DOZE_LSB +: 3]),
    .cpu_en  (cpu_en)
  );

  // clock gating per state; sleep keeps osc_sel_ff so wake resumes on it
  // outputs follow the next state, so they change at the entry edge itself
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cpu_clk_en_ff     <= 1'b1;
      sys_clk_en_ff     <= 1'b1;
      periph_clk_en_ff  <= 1'b1;
      lp_rc_en_ff       <= 1'b0;
      monitor_active_ff <= 1'b0;
    end else begin
      unique case (nxt_state)
        PSMC_SLEEP: begin
          // only the rc clock may survive, and only for the watchdog
          cpu_clk_en_ff     <= 1'b0;
          sys_clk_en_ff     <= 1'b0;
          periph_clk_en_ff  <= 1'b0;
          lp_rc_en_ff       <= watchdog_en;
          monitor_active_ff <= 1'b0;
        end
        PSMC_IDLE: begin
          // peripherals keep the system clock, only the cpu stops
          cpu_clk_en_ff     <= 1'b0;
          sys_clk_en_ff     <= 1'b1;
          periph_clk_en_ff  <= 1'b1;
          lp_rc_en_ff       <= watchdog_en || monitor_en;
          monitor_active_ff <= monitor_en;
        end
        default: begin
          cpu_clk_en_ff     <= cpu_en;
          sys_clk_en_ff     <= 1'b1;
          periph_clk_en_ff  <= 1'b1;
          lp_rc_en_ff       <= watchdog_en || monitor_en;
          monitor_active_ff <= monitor_en;
        end
      endcase
    end
  end

  // regulator controls only while sleeping
  // band gaps read on outside sleep; fast wake trades current for recovery time
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ret_reg_en_ff <= 1'b0;
      bandgap_en_ff <= 1'b1;
      sleep_var_ff  <= 2'h0;
    end else if (nxt_state == PSMC_SLEEP) begin
      ret_reg_en_ff <= retention_en && !cfg_ff[`PSMC_CFG_RET_CFG_N_BIT];
      bandgap_en_ff <= fast_wake;
      sleep_var_ff  <= sleep_var(retention_en, fast_wake);
    end else begin
      ret_reg_en_ff <= 1'b0;
      bandgap_en_ff <= 1'b1;
      sleep_var_ff  <= 2'h0;
    end
  end
endmodule : psmc_top
